// ==== common/adc_scan_pkg.sv ====
// Constants, register map and types shared by the scan sequencer files
package adc_scan_pkg;

  // Clock and timebase
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned BASE_LO_MHZ      = 11;
  localparam int unsigned BASE_HI_MHZ      = 33;
  localparam int unsigned ACC_W            = 8;
  localparam logic [ACC_W-1:0] CLK_RATE    = ACC_W'(CLK_MHZ);
  localparam logic [ACC_W-1:0] BASE_LO     = ACC_W'(BASE_LO_MHZ);
  localparam logic [ACC_W-1:0] BASE_HI     = ACC_W'(BASE_HI_MHZ);

  // Longest hold processing time, rounded down to whole cycles
  localparam int unsigned HOLD_LATENCY_NS  = 15;
  localparam int unsigned HOLD_LATENCY_RAW = HOLD_LATENCY_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_LATENCY_CYC =
    (HOLD_LATENCY_RAW < 1) ? 1 : HOLD_LATENCY_RAW;

  // Widths
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned DIV_W      = 24;
  localparam int unsigned CHAN_W     = 6;
  localparam int unsigned GAIN_W     = 2;
  localparam int unsigned ENTRY_W    = CHAN_W + GAIN_W;
  localparam int unsigned LIST_DEPTH = 16;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned SETTLE_W   = 16;
  localparam int unsigned SYNC_N     = 2;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CONFIG    = 5'h00;
  localparam logic [ADDR_W-1:0] REG_SCAN_DIV  = 5'h04;
  localparam logic [ADDR_W-1:0] REG_CONV_DIV  = 5'h08;
  localparam logic [ADDR_W-1:0] REG_COMMAND   = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_LIST_DATA = 5'h10;
  localparam logic [ADDR_W-1:0] REG_LIST_LAST = 5'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 5'h18;
  localparam logic [ADDR_W-1:0] REG_SETTLE    = 5'h1c;

  // Config fields
  localparam int unsigned CFG_SCAN_SEL_LO = 0;
  localparam int unsigned CFG_SCAN_SEL_HI = 1;
  localparam int unsigned CFG_CONV_SEL_LO = 2;
  localparam int unsigned CFG_CONV_SEL_HI = 3;
  localparam int unsigned CFG_BASE_SEL    = 4;
  localparam int unsigned CFG_SIMUL       = 5;
  localparam int unsigned CFG_W           = 6;

  // Command fields
  localparam int unsigned CMD_SCAN     = 0;
  localparam int unsigned CMD_CONV     = 1;
  localparam int unsigned CMD_CLR_ERR  = 2;
  localparam int unsigned CMD_LIST_RST = 3;

  // Status fields
  localparam int unsigned STAT_ERR    = 0;
  localparam int unsigned STAT_ACTIVE = 1;
  localparam int unsigned STAT_HOLD   = 2;
  localparam int unsigned STAT_IDX_LO = 4;

  // Entry layout: channel low, gain high
  localparam int unsigned ENT_CHAN_LO = 0;
  localparam int unsigned ENT_GAIN_LO = CHAN_W;

  // Reset values
  localparam logic [CFG_W-1:0]    CFG_RESET    = 6'h00;
  localparam logic [DIV_W-1:0]    DIV_RESET    = 24'h000000;
  localparam logic [SETTLE_W-1:0] SETTLE_RESET = 16'h0010;
  localparam logic [IDX_W-1:0]    IDX_RESET    = 4'h0;

  typedef enum logic [1:0] {
    SRC_SW   = 2'h0,
    SRC_INT  = 2'h1,
    SRC_EXT  = 2'h2,
    SRC_CONT = 2'h3
  } src_t;

  // Gray coded along idle, settle, wait, convert
  typedef enum logic [1:0] {
    ST_IDLE      = 2'h0,
    ST_SETTLE    = 2'h1,
    ST_WAIT_CONV = 2'h3,
    ST_CONVERT   = 2'h2
  } seq_state_t;

endpackage : adc_scan_pkg

// ==== core/tick_divider.sv ====
// Programmable divider of the base timebase ticks
module tick_divider (
  input  wire logic                         clk_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         base_tick_i,
  input  wire logic                         run_i,
  input  wire logic [adc_scan_pkg::DIV_W-1:0] divisor_i,
  output logic                              tick_o
);

  logic [adc_scan_pkg::DIV_W-1:0] cnt;
  logic [adc_scan_pkg::DIV_W-1:0] next_cnt;
  logic                           next_tick;

  // Count divisor plus one base ticks per output tick
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run_i) begin
      next_cnt = '0;            // Restart phase whenever deselected
    end else if (base_tick_i) begin
      if (cnt >= divisor_i) begin
        next_cnt  = '0;         // R9
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;  // R8
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule : tick_divider

// ==== core/adc_scan_sequencer.sv ====
// Scan and conversion sequencer for a multichannel acquisition front end
//
// Behaviour
// [R1] Scan pulse starts one pass through list
// [R2] Conversion pulse starts current entry conversion
// [R3] Early scan pulse discarded, error bit set
// [R4] After last entry reload list, preset mux
// [R5] Scan and conversion sources chosen independently
// [R6] Software command gives exactly one pulse
// [R7] Internal base is 11 or 33 MHz
// [R8] Internal clock uses 24-bit divisor
// [R9] Internal rate is base over divisor+1
// [R10] External clocks accepted and both exported
// [R11] Samples follow each other at configured rate
// [R12] Multiplexed: next scan starts without gap
// [R13] Simultaneous: all hold on conversion, then track; hold_o rises on the scan pulse
// [R14] Simultaneous: settling delay before first entry
// [R15] Hold request processed within 15 ns
// [R16] Entry holds channel and its own gain
// [R17] Two-bit selector, reset value software
// [R18] Conversion pulses ignored until scan activates
// [R19] Error bit sticky until software clears
module adc_scan_sequencer (
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic [adc_scan_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [adc_scan_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                            wr_i,
  input  wire logic                            rd_i,
  output logic      [adc_scan_pkg::DATA_W-1:0] rd_data_o,
  input  wire logic                            scan_clock_ext_i,
  input  wire logic                            conv_clock_ext_i,
  input  wire logic                            conv_done_i,
  output logic                                 scan_clock_o,
  output logic                                 conversion_clock_o,
  output logic                                 convert_start_o,
  output logic      [adc_scan_pkg::CHAN_W-1:0] mux_channel_o,
  output logic      [adc_scan_pkg::GAIN_W-1:0] gain_o,
  output logic                                 hold_o,
  output logic                                 scan_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [adc_scan_pkg::CFG_W-1:0]    cfg;
  logic [adc_scan_pkg::DIV_W-1:0]    scan_div;
  logic [adc_scan_pkg::DIV_W-1:0]    conv_div;
  logic [adc_scan_pkg::SETTLE_W-1:0] settle_len;
  logic [adc_scan_pkg::IDX_W-1:0]    list_last;
  logic [adc_scan_pkg::IDX_W-1:0]    wr_ptr;
  logic [adc_scan_pkg::CFG_W-1:0]    next_cfg;
  logic [adc_scan_pkg::DIV_W-1:0]    next_scan_div;
  logic [adc_scan_pkg::DIV_W-1:0]    next_conv_div;
  logic [adc_scan_pkg::SETTLE_W-1:0] next_settle_len;
  logic [adc_scan_pkg::IDX_W-1:0]    next_list_last;
  logic [adc_scan_pkg::IDX_W-1:0]    next_wr_ptr;
  logic [adc_scan_pkg::DATA_W-1:0]   next_rd_data;
  logic                              err;
  logic                              next_err;

  logic [adc_scan_pkg::ENTRY_W-1:0]  list_mem [adc_scan_pkg::LIST_DEPTH];
  logic                              list_we;

  logic [adc_scan_pkg::ACC_W-1:0]    acc;
  logic [adc_scan_pkg::ACC_W-1:0]    next_acc;
  logic                              base_tick;
  logic                              next_base_tick;
  logic                              scan_tick;
  logic                              conv_tick;

  logic [adc_scan_pkg::SYNC_N-1:0]   sync1;
  logic [adc_scan_pkg::SYNC_N-1:0]   sync2;
  logic [adc_scan_pkg::SYNC_N-1:0]   sync3;
  logic [adc_scan_pkg::SYNC_N-1:0]   ext_lvl;
  logic [adc_scan_pkg::SYNC_N-1:0]   next_ext_lvl;
  logic [adc_scan_pkg::SYNC_N-1:0]   ext_rise;

  adc_scan_pkg::seq_state_t          state;
  adc_scan_pkg::seq_state_t          next_state;
  logic [adc_scan_pkg::IDX_W-1:0]    idx;
  logic [adc_scan_pkg::IDX_W-1:0]    next_idx;
  logic [adc_scan_pkg::SETTLE_W-1:0] settle_cnt;
  logic [adc_scan_pkg::SETTLE_W-1:0] next_settle_cnt;
  logic                              next_hold;
  logic                              next_start;
  logic [adc_scan_pkg::ENTRY_W-1:0]  next_entry;

  adc_scan_pkg::src_t                scan_sel;
  adc_scan_pkg::src_t                conv_sel;
  logic                              simul;
  logic                              cmd_wr;
  logic                              sw_scan;
  logic                              sw_conv;
  logic                              last_done;
  logic                              scan_ready;
  logic                              conv_ready;
  logic                              scan_pulse;
  logic                              conv_pulse;
  logic                              scan_take;
  logic                              conv_take;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection

  // Pick the pulse of the selected source; continuous fires when ready
  function automatic logic pick_pulse(
    input adc_scan_pkg::src_t sel,
    input logic               sw,
    input logic               tick,
    input logic               ext,
    input logic               ready
  );
    case (sel)
      adc_scan_pkg::SRC_SW:   pick_pulse = sw;
      adc_scan_pkg::SRC_INT:  pick_pulse = tick;
      adc_scan_pkg::SRC_EXT:  pick_pulse = ext;
      adc_scan_pkg::SRC_CONT: pick_pulse = ready;
      default:                pick_pulse = 1'b0;
    endcase
  endfunction : pick_pulse

  // Two-bit selectors per clock, both reset to software
  assign scan_sel = adc_scan_pkg::src_t'({cfg[adc_scan_pkg::CFG_SCAN_SEL_HI],
                    cfg[adc_scan_pkg::CFG_SCAN_SEL_LO]});       // R5 R17
  assign conv_sel = adc_scan_pkg::src_t'({cfg[adc_scan_pkg::CFG_CONV_SEL_HI],
                    cfg[adc_scan_pkg::CFG_CONV_SEL_LO]});       // R5 R17
  assign simul    = cfg[adc_scan_pkg::CFG_SIMUL];

  // Software pulses: one register write gives one pulse
  assign cmd_wr  = wr_i && (addr_i == adc_scan_pkg::REG_COMMAND);
  assign sw_scan = cmd_wr && wr_data_i[adc_scan_pkg::CMD_SCAN];  // R6
  assign sw_conv = cmd_wr && wr_data_i[adc_scan_pkg::CMD_CONV];  // R6

  // Readiness: S/H must track again, so only multiplexed chains scans
  assign last_done  = (state == adc_scan_pkg::ST_CONVERT) && conv_done_i &&
                      (idx == list_last) && !simul;             // R12
  assign scan_ready = (state == adc_scan_pkg::ST_IDLE) || last_done;
  assign conv_ready = (state == adc_scan_pkg::ST_WAIT_CONV);    // R18

  assign scan_pulse = pick_pulse(scan_sel, sw_scan, scan_tick,
                                 ext_rise[0], scan_ready);
  assign conv_pulse = pick_pulse(conv_sel, sw_conv, conv_tick,
                                 ext_rise[1], conv_ready);
  assign scan_take  = scan_pulse && scan_ready;                 // R1
  assign conv_take  = conv_pulse && conv_ready;                 // R2 R18

  ////////////////////////////////////////////////////////////////////////////
  // Internal timebase

  // Phase accumulator gives an exact average base rate from the clock
  always_comb begin
    logic [adc_scan_pkg::ACC_W-1:0] sum;
    sum = acc + (cfg[adc_scan_pkg::CFG_BASE_SEL] ?
                 adc_scan_pkg::BASE_HI : adc_scan_pkg::BASE_LO); // R7
    next_base_tick = 1'b0;
    next_acc       = sum;
    if (sum >= adc_scan_pkg::CLK_RATE) begin
      next_acc       = sum - adc_scan_pkg::CLK_RATE;
      next_base_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc       <= '0;
      base_tick <= 1'b0;
    end else begin
      acc       <= next_acc;
      base_tick <= next_base_tick;
    end
  end

  // Each clock has its own divider so rates stay independent
  tick_divider scan_divider (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .base_tick_i (base_tick),
    .run_i       (scan_sel == adc_scan_pkg::SRC_INT),
    .divisor_i   (scan_div),
    .tick_o      (scan_tick)
  );

  tick_divider conv_divider (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .base_tick_i (base_tick),
    .run_i       (conv_sel == adc_scan_pkg::SRC_INT),
    .divisor_i   (conv_div),
    .tick_o      (conv_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // External clock inputs

  // Level follows once stages two and three agree; rising edge counts
  always_comb begin
    next_ext_lvl = ext_lvl;
    for (int i = 0; i < adc_scan_pkg::SYNC_N; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_ext_lvl[i] = sync3[i];
      end
    end
  end

  assign ext_rise = sync2 & sync3 & ~ext_lvl;                   // R10

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1   <= '0;
      sync2   <= '0;
      sync3   <= '0;
      ext_lvl <= '0;
    end else begin
      sync1   <= {conv_clock_ext_i, scan_clock_ext_i};
      sync2   <= sync1;
      sync3   <= sync2;
      ext_lvl <= next_ext_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Walk the list; each accepted conversion pulse starts one sample
  always_comb begin
    next_state      = state;
    next_idx        = idx;
    next_hold       = hold_o;
    next_settle_cnt = settle_cnt;
    next_start      = 1'b0;
    case (state)
      adc_scan_pkg::ST_IDLE: begin
        if (scan_take) begin
          next_idx = '0;                                        // R1
          if (simul) begin
            next_hold       = 1'b1;                             // R13 R15
            next_settle_cnt = settle_len;
            next_state      = adc_scan_pkg::ST_SETTLE;          // R14
          end else begin
            next_state = adc_scan_pkg::ST_WAIT_CONV;
          end
        end
      end
      adc_scan_pkg::ST_SETTLE: begin
        if (settle_cnt == '0) begin
          next_state = adc_scan_pkg::ST_WAIT_CONV;              // R14
        end else begin
          next_settle_cnt = settle_cnt - 1'b1;
        end
      end
      adc_scan_pkg::ST_WAIT_CONV: begin
        if (conv_take) begin
          next_start = 1'b1;                                    // R2 R11
          next_state = adc_scan_pkg::ST_CONVERT;
        end
      end
      adc_scan_pkg::ST_CONVERT: begin
        if (conv_done_i) begin
          if (idx == list_last) begin
            next_idx  = '0;                                     // R4
            next_hold = 1'b0;                                   // R13
            if (scan_take) begin
              next_state = adc_scan_pkg::ST_WAIT_CONV;          // R12
            end else begin
              next_state = adc_scan_pkg::ST_IDLE;
            end
          end else begin
            next_idx   = idx + 1'b1;                            // R11
            next_state = adc_scan_pkg::ST_WAIT_CONV;
          end
        end
      end
      default: begin
        next_state = adc_scan_pkg::ST_IDLE;
        next_hold  = 1'b0;
      end
    endcase
    next_entry = list_mem[next_idx];                            // R4 R16
  end

  // Mux and gain follow the entry that comes next, so they settle early
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state              <= adc_scan_pkg::ST_IDLE;
      idx                <= adc_scan_pkg::IDX_RESET;
      settle_cnt         <= '0;
      hold_o             <= 1'b0;
      convert_start_o    <= 1'b0;
      mux_channel_o      <= '0;
      gain_o             <= '0;
      scan_clock_o       <= 1'b0;
      conversion_clock_o <= 1'b0;
      scan_active_o      <= 1'b0;
    end else begin
      state              <= next_state;
      idx                <= next_idx;
      settle_cnt         <= next_settle_cnt;
      hold_o             <= next_hold;
      convert_start_o    <= next_start;
      mux_channel_o      <= next_entry[adc_scan_pkg::ENT_CHAN_LO +:
                                       adc_scan_pkg::CHAN_W];   // R16
      gain_o             <= next_entry[adc_scan_pkg::ENT_GAIN_LO +:
                                       adc_scan_pkg::GAIN_W];   // R16
      scan_clock_o       <= scan_take;                          // R10
      conversion_clock_o <= conv_take;                          // R10
      scan_active_o      <= (next_state != adc_scan_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  // Writes, list pointer and sticky error; a new error beats the clear
  always_comb begin
    next_cfg        = cfg;
    next_scan_div   = scan_div;
    next_conv_div   = conv_div;
    next_settle_len = settle_len;
    next_list_last  = list_last;
    next_wr_ptr     = wr_ptr;
    list_we         = 1'b0;
    if (wr_i) begin
      case (addr_i)
        adc_scan_pkg::REG_CONFIG:
          next_cfg = wr_data_i[adc_scan_pkg::CFG_W-1:0];
        adc_scan_pkg::REG_SCAN_DIV:
          next_scan_div = wr_data_i[adc_scan_pkg::DIV_W-1:0];   // R8
        adc_scan_pkg::REG_CONV_DIV:
          next_conv_div = wr_data_i[adc_scan_pkg::DIV_W-1:0];   // R8
        adc_scan_pkg::REG_SETTLE:
          next_settle_len = wr_data_i[adc_scan_pkg::SETTLE_W-1:0];
        adc_scan_pkg::REG_LIST_LAST:
          next_list_last = wr_data_i[adc_scan_pkg::IDX_W-1:0];
        adc_scan_pkg::REG_LIST_DATA: begin
          list_we     = 1'b1;
          next_wr_ptr = wr_ptr + 1'b1;
        end
        adc_scan_pkg::REG_COMMAND: begin
          if (wr_data_i[adc_scan_pkg::CMD_LIST_RST]) begin
            next_wr_ptr = '0;
          end
        end
        default: begin
        end
      endcase
    end
    next_err = err;
    if (cmd_wr && wr_data_i[adc_scan_pkg::CMD_CLR_ERR]) begin
      next_err = 1'b0;                                          // R19
    end
    if (scan_pulse && !scan_ready) begin
      next_err = 1'b1;                                          // R3 R19
    end
  end

  // Read data appear the cycle after the strobe; unmapped reads zero
  always_comb begin
    next_rd_data = '0;
    if (rd_i) begin
      case (addr_i)
        adc_scan_pkg::REG_CONFIG:    next_rd_data = 32'(cfg);
        adc_scan_pkg::REG_SCAN_DIV:  next_rd_data = 32'(scan_div);
        adc_scan_pkg::REG_CONV_DIV:  next_rd_data = 32'(conv_div);
        adc_scan_pkg::REG_SETTLE:    next_rd_data = 32'(settle_len);
        adc_scan_pkg::REG_LIST_LAST: next_rd_data = 32'(list_last);
        adc_scan_pkg::REG_STATUS: begin
          next_rd_data[adc_scan_pkg::STAT_ERR]    = err;
          next_rd_data[adc_scan_pkg::STAT_ACTIVE] = scan_active_o;
          next_rd_data[adc_scan_pkg::STAT_HOLD]   = hold_o;
          next_rd_data[adc_scan_pkg::STAT_IDX_LO +: adc_scan_pkg::IDX_W] = idx;
        end
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg        <= adc_scan_pkg::CFG_RESET;                    // R17
      scan_div   <= adc_scan_pkg::DIV_RESET;
      conv_div   <= adc_scan_pkg::DIV_RESET;
      settle_len <= adc_scan_pkg::SETTLE_RESET;
      list_last  <= adc_scan_pkg::IDX_RESET;
      wr_ptr     <= adc_scan_pkg::IDX_RESET;
      err        <= 1'b0;
      rd_data_o  <= '0;
    end else begin
      cfg        <= next_cfg;
      scan_div   <= next_scan_div;
      conv_div   <= next_conv_div;
      settle_len <= next_settle_len;
      list_last  <= next_list_last;
      wr_ptr     <= next_wr_ptr;
      err        <= next_err;
      rd_data_o  <= next_rd_data;
    end
  end

  // Entry store; no reset, software fills it before the first scan
  always_ff @(posedge clk_i) begin
    if (list_we) begin
      list_mem[wr_ptr] <= wr_data_i[adc_scan_pkg::ENTRY_W-1:0];  // R16
    end
  end

endmodule : adc_scan_sequencer

// ==== sim/conv_model.sv ====
// Behavioural converter answering each start with one done pulse
module conv_model #(
  parameter int DELAY = 3
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic start_i,
  output logic      done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Done only after a start, never spontaneously
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt    <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt == 1);
      if (start_i) cnt <= DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule : conv_model

// ==== sim/adc_scan_sequencer_properties.sv ====
// Port checker of the scan sequencer
module adc_scan_sequencer_properties (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [4:0]  addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic        wr_i,
  input wire logic        conv_done_i,
  input wire logic        scan_clock_o,
  input wire logic        conversion_clock_o,
  input wire logic        convert_start_o,
  input wire logic        hold_o,
  input wire logic        scan_active_o
);
  logic [5:0] cfg;
  logic       sw_scan;
  // Config shadow: source rules depend on the mode
  assign sw_scan = wr_i && addr_i == adc_scan_pkg::REG_COMMAND &&
                   wr_data_i[0] && cfg[1:0] == 2'h0;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cfg <= 6'h00;
    else if (wr_i && addr_i == adc_scan_pkg::REG_CONFIG)
      cfg <= wr_data_i[5:0];
  end
  //////////////////////////////
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_pair; convert_start_o == conversion_clock_o; endproperty
  a_pair: assert property (p_pair)
    else $error("start and exported clock differ");
  property p_active; scan_clock_o |-> scan_active_o; endproperty
  a_active: assert property (p_active)
    else $error("scan pulse without active scan");
  property p_gated; convert_start_o |-> $past(scan_active_o); endproperty
  a_gated: assert property (p_gated)
    else $error("conversion outside a scan");
  property p_sw_scan; sw_scan && !scan_active_o |=> scan_clock_o; endproperty
  a_sw_scan: assert property (p_sw_scan)
    else $error("software scan gave no pulse");
  property p_busy;
    sw_scan && scan_active_o && !conv_done_i && !$past(conv_done_i)
      |=> !scan_clock_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("early scan pulse accepted");
  property p_hold_mode; scan_clock_o |-> hold_o == cfg[5]; endproperty
  a_hold_mode: assert property (p_hold_mode)
    else $error("hold level wrong at scan start");
  property p_hold_keep;
    hold_o && !conv_done_i && !$past(conv_done_i) |=> hold_o;
  endproperty
  a_hold_keep: assert property (p_hold_keep)
    else $error("hold released early");
  property p_settle; $rose(hold_o) |-> !convert_start_o [*2]; endproperty
  a_settle: assert property (p_settle)
    else $error("conversion without settling");
endmodule : adc_scan_sequencer_properties
bind adc_scan_sequencer adc_scan_sequencer_properties u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .conv_done_i(conv_done_i),
  .scan_clock_o(scan_clock_o), .conversion_clock_o(conversion_clock_o),
  .convert_start_o(convert_start_o), .hold_o(hold_o),
  .scan_active_o(scan_active_o));

// ==== sim/adc_scan_sequencer_tb.sv ====
// Self-checking bench of the scan sequencer
module adc_scan_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [4:0]  addr_i = 5'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        scan_ext = 1'b0;
  logic        conv_ext = 1'b0;
  logic [31:0] rd_data_o;
  logic        conv_done_i, scan_clock_o, conversion_clock_o;
  logic        convert_start_o, hold_o, scan_active_o;
  logic [5:0]  mux;
  logic [1:0]  gain;
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0, ns = 0, nc = 0, n;
  adc_scan_sequencer u_adc_scan_sequencer (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .scan_clock_ext_i(scan_ext), .conv_clock_ext_i(conv_ext),
    .conv_done_i(conv_done_i), .scan_clock_o(scan_clock_o),
    .conversion_clock_o(conversion_clock_o),
    .convert_start_o(convert_start_o), .mux_channel_o(mux),
    .gain_o(gain), .hold_o(hold_o), .scan_active_o(scan_active_o));
  conv_model u_conv_model (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .start_i(convert_start_o), .done_o(conv_done_i));
  always #5 clk_i = ~clk_i;
  // Pulse tallies on the falling edge, away from output updates
  always @(negedge clk_i) begin
    cyc++;
    ns += scan_clock_o;
    nc += convert_start_o;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  //////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(int k);
    repeat (k) @(negedge clk_i);
  endtask : tick
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic cmd(logic [31:0] d);
    wr(adc_scan_pkg::REG_COMMAND, d);
  endtask : cmd
  task automatic rd(logic [4:0] a, logic [31:0] e, string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    tick(1);
    chk(nm, e, rd_data_o);
  endtask : rd
  // External pin held a few cycles, so the synchroniser sees it
  task automatic ext_pulse(bit s);
    @(posedge clk_i);
    if (s) scan_ext <= 1'b1;
    else conv_ext <= 1'b1;
    repeat (3) @(posedge clk_i);
    scan_ext <= 1'b0;
    conv_ext <= 1'b0;
    tick(12);
  endtask : ext_pulse
  task automatic s_reset;
    rd(adc_scan_pkg::REG_CONFIG, 32'h0, "config");
    rd(adc_scan_pkg::REG_SETTLE, 32'h10, "settle");
    rd(5'h02, 32'h0, "unmapped");
  endtask : s_reset
  task automatic s_mux;
    wr(adc_scan_pkg::REG_LIST_DATA, 32'h45);
    wr(adc_scan_pkg::REG_LIST_DATA, 32'haa);
    wr(adc_scan_pkg::REG_LIST_LAST, 32'h1);
    cmd(32'ha);
    tick(4);
    chk("idle conv", 0, nc);
    cmd(32'h1);
    tick(2);
    chk("scan", 1, ns);
    chk("entry0", 32'h45, {gain, mux});
    cmd(32'h2);
    tick(8);
    chk("conv", 1, nc);
    chk("entry1", 32'haa, {gain, mux});
    cmd(32'h2);
    tick(8);
    chk("active", 0, scan_active_o);
    chk("preset", 32'h45, {gain, mux});
  endtask : s_mux
  task automatic s_error;
    cmd(32'h1);
    cmd(32'h1);
    tick(2);
    chk("scans", 2, ns);
    rd(adc_scan_pkg::REG_STATUS, 32'h3, "err set");
    cmd(32'h2);
    tick(8);
    rd(adc_scan_pkg::REG_STATUS, 32'h13, "err kept");
    cmd(32'h2);
    tick(8);
    cmd(32'h4);
    rd(adc_scan_pkg::REG_STATUS, 32'h0, "err clear");
  endtask : s_error
  // Rate windows allow one tick of accumulator jitter
  task automatic s_rate;
    wr(adc_scan_pkg::REG_CONV_DIV, 32'h2);
    wr(adc_scan_pkg::REG_SCAN_DIV, 32'h2);
    wr(adc_scan_pkg::REG_CONFIG, 32'h0d);
    nc = 0;
    tick(600);
    chk("rate lo", 1, nc inside {[41:46]});
    wr(adc_scan_pkg::REG_CONFIG, 32'h17);
    nc = 0;
    tick(600);
    chk("rate hi", 1, nc inside {[64:68]});
    wr(adc_scan_pkg::REG_CONFIG, 32'h0c);
    tick(20);
    rd(adc_scan_pkg::REG_STATUS, 32'h0, "rate idle");
  endtask : s_rate
  task automatic s_ext;
    wr(adc_scan_pkg::REG_CONFIG, 32'h0a);
    ns = 0;
    nc = 0;
    ext_pulse(1'b1);
    ext_pulse(1'b0);
    ext_pulse(1'b0);
    chk("ext scan", 1, ns);
    chk("ext conv", 2, nc);
  endtask : s_ext
  task automatic s_simul;
    wr(adc_scan_pkg::REG_SETTLE, 32'h4);
    wr(adc_scan_pkg::REG_CONFIG, 32'h2c);
    cmd(32'h1);
    for (n = 0; n < 40 && convert_start_o !== 1'b1; n++) tick(1);
    chk("hold", 1, hold_o);
    chk("settle", 1, n inside {[5:9]});
    tick(20);
    chk("track", 0, hold_o);
    wr(adc_scan_pkg::REG_LIST_DATA, 32'h3f);
    tick(2);
    chk("list rst", 32'h3f, {gain, mux});
  endtask : s_simul
  task automatic finish_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    s_reset();
    s_mux();
    s_error();
    s_rate();
    s_ext();
    s_simul();
    finish_test();
  end
endmodule : adc_scan_sequencer_tb
